// File: verilog/gde_cfg.svh
// Register offsets, field positions, reset values and timing counts of the drawing block.
`ifndef GDE_CFG_SVH
`define GDE_CFG_SVH

// Byte offsets of the register map (low byte of two-byte registers; high byte sits at offset plus one).
`define GDE_OFS_AW_HEIGHT 8'h5c
`define GDE_OFS_CANVAS 8'h5e
`define GDE_OFS_GPOS_H 8'h5f
`define GDE_OFS_GPOS_V 8'h61
`define GDE_OFS_TPOS_H 8'h63
`define GDE_OFS_TPOS_V 8'h65
`define GDE_OFS_POLY_CTRL 8'h67
`define GDE_OFS_P1_H 8'h68
`define GDE_OFS_P1_V 8'h6a
`define GDE_OFS_P2_H 8'h6c
`define GDE_OFS_P2_V 8'h6e
`define GDE_OFS_P3_H 8'h70
`define GDE_OFS_P3_V 8'h72
`define GDE_OFS_CURVE_CTRL 8'h76
`define GDE_OFS_RAD_MAJOR 8'h77
`define GDE_OFS_RAD_MINOR 8'h79
`define GDE_OFS_CENTER_H 8'h7b
`define GDE_OFS_CENTER_V 8'h7d
`define GDE_OFS_FG_RED 8'hd2

// Field positions.
`define GDE_BIT_START 7
`define GDE_BIT_CURVE_FILL 6
`define GDE_BIT_POLY_FILL 5
`define GDE_BIT_READ_SEL 3
`define GDE_BIT_LINEAR 2

// Valid bits of the high bytes and reset values.
`define GDE_HI_MASK_14 8'h3f
`define GDE_HI_MASK_13 8'h1f
`define GDE_RST_FG_RED 8'hff

// Length of one drawing operation in core clock cycles.
`define GDE_DRAW_CYCLES 16'h0040

`endif

// File: verilog/gde_pkg.sv
// Types shared by the drawing register block.
package gde_pkg;

    // Drawing sequencer states.
    typedef enum logic [0:0] {GDE_IDLE, GDE_DRAW} gde_state_t;

    // What the pixel engine is to produce once degenerate triangles are folded.
    typedef enum logic [1:0] {GDE_KIND_SHAPE, GDE_KIND_LINE, GDE_KIND_DOT} gde_kind_t;

    // Command handed to the pixel engine at the start of a drawing.
    typedef struct packed {
        logic curve;         // 0: polygon control started it, 1: curve control.
        gde_kind_t kind;     // Folded triangle class.
        logic [3:0] shape;   // Polygon shape code or curve shape in low bits.
        logic fill;          // Filled or outline.
        logic [1:0] quarter; // Quarter curve select.
        logic [12:0] p1x;
        logic [12:0] p1y;
        logic [12:0] p2x;
        logic [12:0] p2y;
        logic [12:0] p3x;
        logic [12:0] p3y;
        logic [12:0] cx;
        logic [12:0] cy;
        logic [12:0] ra;
        logic [12:0] rb;
    } gde_draw_t;

endpackage : gde_pkg

// File: verilog/gde_regs.sv
// Control and status registers of the geometric drawing engine and canvas access logic.
//
// Contract
// - Window height is 14 bits, high bits ignored.
// - Window height ignored in linear addressing mode.
// - Canvas bit 3 selects read or write position.
// - Canvas bit 2 selects block or linear addressing.
// - Block mode bits 1:0 give pixel depth.
// - Linear mode bit 0 gives 8/16-bit access.
// - Horizontal position: linear low address, block X.
// - Vertical position: linear high address, block Y.
// - Text positions hold 13-bit coordinates, read back.
// - Polygon bit 7 starts, stops, reports busy.
// - Polygon bit 5 selects fill or outline.
// - Polygon bits 4:1 select the shape.
// - Three endpoints hold 13-bit X and Y.
// - Coinciding triangle points draw line or dot.
// - Curve bit 7 starts, stops, reports busy.
// - Curve bit 6 selects fill or outline.
// - Curve bits 5:4 select the shape.
// - Curve bits 1:0 pick the quarter curve.
// - Red foreground resets to ff, masked per depth.
`timescale 1ns/1ps
`include "gde_cfg.svh"

module gde_regs (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Byte register port.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Canvas access strobes from the memory port.
    input wire logic mem_wr_done,
    input wire logic mem_rd_done,
    // Canvas configuration.
    output logic canvas_linear,
    output logic [1:0] canvas_depth,
    output logic mem_access_16,
    output logic [13:0] window_height_eff,
    // Cursors.
    output logic [15:0] write_pos_x,
    output logic [15:0] write_pos_y,
    output logic [15:0] read_pos_x,
    output logic [15:0] read_pos_y,
    output logic [12:0] text_pos_x,
    output logic [12:0] text_pos_y,
    // Drawing.
    output gde_pkg::gde_draw_t draw_cmd,
    output logic draw_busy,
    output logic [7:0] foreground_red_eff
);
    import gde_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage.

    logic [13:0] aw_height;      // Active window height.
    logic [3:0] canvas_cfg;      // Read select, linear mode, depth bits.
    logic [12:0] tpos_x;         // Text write X.
    logic [12:0] tpos_y;         // Text write Y.
    logic poly_fill;             // Polygon fill select.
    logic [3:0] poly_shape;      // Polygon shape code.
    logic [12:0] pt [0:5];       // Endpoints: p1x, p1y, p2x, p2y, p3x, p3y.
    logic curve_fill;            // Curve fill select.
    logic [1:0] curve_shape;     // Curve shape code.
    logic [1:0] quarter;         // Quarter curve select.
    logic [12:0] rad_major;      // Major radius.
    logic [12:0] rad_minor;      // Minor radius.
    logic [12:0] center_x;       // Centre X.
    logic [12:0] center_y;       // Centre Y.
    logic [7:0] fg_red;          // Red foreground byte.
    logic [15:0] wpos_h;         // Graphic write position, horizontal.
    logic [15:0] wpos_v;         // Graphic write position, vertical.
    logic [15:0] rpos_h;         // Graphic read (prefetch) position, horizontal.
    logic [15:0] rpos_v;         // Graphic read (prefetch) position, vertical.
    gde_state_t state;           // Drawing sequencer state.
    logic draw_curve;            // Which control register started the drawing.
    logic [15:0] draw_count;     // Cycles left in the current drawing.

    // Write strobes per byte offset.
    function automatic logic hit(input logic [7:0] ofs);
        hit = reg_wr && (reg_addr == ofs);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////////
    // Canvas configuration and window height.

    // Height keeps only six bits of its high byte.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            aw_height <= 14'h0000;
            canvas_cfg <= 4'h0;
        end else begin
            if (hit(`GDE_OFS_AW_HEIGHT)) begin
                aw_height[7:0] <= reg_wdata;
            end
            if (hit(`GDE_OFS_AW_HEIGHT + 8'h01)) begin
                aw_height[13:8] <= reg_wdata[5:0];
            end
            if (hit(`GDE_OFS_CANVAS)) begin
                canvas_cfg <= reg_wdata[3:0];
            end
        end
    end

    // Configuration outputs decoded from the canvas byte, registered.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            canvas_linear <= 1'b0;
            canvas_depth <= 2'h0;
            mem_access_16 <= 1'b0;
            window_height_eff <= 14'h0000;
        end else begin
            canvas_linear <= canvas_cfg[`GDE_BIT_LINEAR];
            // Depth only means something in block mode; 1x is collapsed to 24 bpp.
            canvas_depth <= canvas_cfg[`GDE_BIT_LINEAR] ? 2'h0 :
                (canvas_cfg[1] ? 2'h2 : {1'b0, canvas_cfg[0]});
            mem_access_16 <= canvas_cfg[`GDE_BIT_LINEAR] ? canvas_cfg[0] : 1'b0;
            // The window is not used in linear mode, so its height is withheld.
            window_height_eff <= canvas_cfg[`GDE_BIT_LINEAR] ? 14'h0000 : aw_height;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Graphic read and write positions.

    // A host write sets both cursors; each memory access then moves its own cursor.
    // Positions are kept 16 bits wide so that linear byte addresses fit.
    // Block mode steps one pixel in X; the memory port handles line wrap itself.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wpos_h <= 16'h0000;
            wpos_v <= 16'h0000;
            rpos_h <= 16'h0000;
            rpos_v <= 16'h0000;
        end else begin
            if (hit(`GDE_OFS_GPOS_H)) begin
                wpos_h[7:0] <= reg_wdata;
                rpos_h[7:0] <= reg_wdata;
            end else if (hit(`GDE_OFS_GPOS_H + 8'h01)) begin
                wpos_h[15:8] <= reg_wdata;
                rpos_h[15:8] <= reg_wdata;
            end else if (hit(`GDE_OFS_GPOS_V)) begin
                wpos_v[7:0] <= reg_wdata;
                rpos_v[7:0] <= reg_wdata;
            end else if (hit(`GDE_OFS_GPOS_V + 8'h01)) begin
                wpos_v[15:8] <= reg_wdata;
                rpos_v[15:8] <= reg_wdata;
            end else begin
                if (mem_wr_done) begin
                    if (canvas_cfg[`GDE_BIT_LINEAR]) begin
                        {wpos_v, wpos_h} <= {wpos_v, wpos_h} + (canvas_cfg[0] ? 32'h2 : 32'h1);
                    end else begin
                        wpos_h <= wpos_h + 16'h0001;
                    end
                end
                if (mem_rd_done) begin
                    if (canvas_cfg[`GDE_BIT_LINEAR]) begin
                        {rpos_v, rpos_h} <= {rpos_v, rpos_h} + (canvas_cfg[0] ? 32'h2 : 32'h1);
                    end else begin
                        rpos_h <= rpos_h + 16'h0001;
                    end
                end
            end
        end
    end

    // Cursor outputs; block mode presents 13-bit coordinates.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            write_pos_x <= 16'h0000;
            write_pos_y <= 16'h0000;
            read_pos_x <= 16'h0000;
            read_pos_y <= 16'h0000;
        end else if (canvas_cfg[`GDE_BIT_LINEAR]) begin
            write_pos_x <= wpos_h;
            write_pos_y <= wpos_v;
            read_pos_x <= rpos_h;
            read_pos_y <= rpos_v;
        end else begin
            write_pos_x <= {3'h0, wpos_h[12:0]};
            write_pos_y <= {3'h0, wpos_v[12:0]};
            read_pos_x <= {3'h0, rpos_h[12:0]};
            read_pos_y <= {3'h0, rpos_v[12:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Text position, shape parameters and colour.

    // Byte writes of 13-bit coordinates; the top three bits of each high byte are dropped.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tpos_x <= 13'h0000;
            tpos_y <= 13'h0000;
            rad_major <= 13'h0000;
            rad_minor <= 13'h0000;
            center_x <= 13'h0000;
            center_y <= 13'h0000;
            fg_red <= `GDE_RST_FG_RED;
        end else begin
            if (hit(`GDE_OFS_TPOS_H)) tpos_x[7:0] <= reg_wdata;
            if (hit(`GDE_OFS_TPOS_H + 8'h01)) tpos_x[12:8] <= reg_wdata[4:0];
            if (hit(`GDE_OFS_TPOS_V)) tpos_y[7:0] <= reg_wdata;
            if (hit(`GDE_OFS_TPOS_V + 8'h01)) tpos_y[12:8] <= reg_wdata[4:0];
            if (hit(`GDE_OFS_RAD_MAJOR)) rad_major[7:0] <= reg_wdata;
            if (hit(`GDE_OFS_RAD_MAJOR + 8'h01)) rad_major[12:8] <= reg_wdata[4:0];
            if (hit(`GDE_OFS_RAD_MINOR)) rad_minor[7:0] <= reg_wdata;
            if (hit(`GDE_OFS_RAD_MINOR + 8'h01)) rad_minor[12:8] <= reg_wdata[4:0];
            if (hit(`GDE_OFS_CENTER_H)) center_x[7:0] <= reg_wdata;
            if (hit(`GDE_OFS_CENTER_H + 8'h01)) center_x[12:8] <= reg_wdata[4:0];
            if (hit(`GDE_OFS_CENTER_V)) center_y[7:0] <= reg_wdata;
            if (hit(`GDE_OFS_CENTER_V + 8'h01)) center_y[12:8] <= reg_wdata[4:0];
            if (hit(`GDE_OFS_FG_RED)) fg_red <= reg_wdata;
        end
    end

    // The six endpoint words sit at consecutive even offsets, so a loop covers them.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < 6; i++) begin
                pt[i] <= 13'h0000;
            end
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (hit(`GDE_OFS_P1_H + 8'(2 * i))) begin
                    pt[i][7:0] <= reg_wdata;
                end
                if (hit(`GDE_OFS_P1_H + 8'(2 * i + 1))) begin
                    pt[i][12:8] <= reg_wdata[4:0];
                end
            end
        end
    end

    // Text cursor and colour outputs; red keeps only the bits its depth uses.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            text_pos_x <= 13'h0000;
            text_pos_y <= 13'h0000;
            foreground_red_eff <= `GDE_RST_FG_RED;
        end else begin
            text_pos_x <= tpos_x;
            text_pos_y <= tpos_y;
            // Linear mode has no pixel depth, so red is masked as for 8 bpp, as canvas_depth shows.
            if (!canvas_cfg[`GDE_BIT_LINEAR] && canvas_cfg[1]) begin
                foreground_red_eff <= fg_red;
            end else if (!canvas_cfg[`GDE_BIT_LINEAR] && canvas_cfg[0]) begin
                foreground_red_eff <= {fg_red[7:3], 3'h0};
            end else begin
                foreground_red_eff <= {fg_red[7:5], 5'h00};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shape selection bytes.

    // Mode bits of both control registers; bit 7 is handled by the sequencer.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            poly_fill <= 1'b0;
            poly_shape <= 4'h0;
            curve_fill <= 1'b0;
            curve_shape <= 2'h0;
            quarter <= 2'h0;
        end else begin
            if (hit(`GDE_OFS_POLY_CTRL)) begin
                poly_fill <= reg_wdata[`GDE_BIT_POLY_FILL];
                poly_shape <= reg_wdata[4:1];
            end
            if (hit(`GDE_OFS_CURVE_CTRL)) begin
                curve_fill <= reg_wdata[`GDE_BIT_CURVE_FILL];
                curve_shape <= reg_wdata[5:4];
                quarter <= reg_wdata[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Drawing sequencer.

    // Folding of degenerate triangles from the endpoints as they stand.
    logic p12_eq;
    logic p13_eq;
    logic p23_eq;
    gde_kind_t tri_kind;
    always_comb begin
        p12_eq = (pt[0] == pt[2]) && (pt[1] == pt[3]);
        p13_eq = (pt[0] == pt[4]) && (pt[1] == pt[5]);
        p23_eq = (pt[2] == pt[4]) && (pt[3] == pt[5]);
        if (p12_eq && p13_eq) begin
            tri_kind = GDE_KIND_DOT;
        end else if (p12_eq || p13_eq || p23_eq) begin
            tri_kind = GDE_KIND_LINE;
        end else begin
            tri_kind = GDE_KIND_SHAPE;
        end
    end

    // The write data of a control register carries the new mode bits too, so the
    // command is built from reg_wdata rather than from the stored copy.
    // A start while drawing is ignored; a stop aborts only from the register that started it.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= GDE_IDLE;
            draw_curve <= 1'b0;
            draw_count <= 16'h0000;
            draw_cmd <= '0;
        end else begin
            unique case (state)
                GDE_IDLE: begin
                    if (hit(`GDE_OFS_POLY_CTRL) && reg_wdata[`GDE_BIT_START]) begin
                        state <= GDE_DRAW;
                        draw_curve <= 1'b0;
                        draw_count <= `GDE_DRAW_CYCLES;
                        draw_cmd <= '0;
                        draw_cmd.shape <= reg_wdata[4:1];
                        draw_cmd.fill <= reg_wdata[`GDE_BIT_POLY_FILL];
                        draw_cmd.kind <= (reg_wdata[4:1] == 4'h1) ? tri_kind
                                                                : GDE_KIND_SHAPE;
                        {draw_cmd.p1x, draw_cmd.p1y, draw_cmd.p2x} <= {pt[0], pt[1], pt[2]};
                        {draw_cmd.p2y, draw_cmd.p3x, draw_cmd.p3y} <= {pt[3], pt[4], pt[5]};
                    end else if (hit(`GDE_OFS_CURVE_CTRL) && reg_wdata[`GDE_BIT_START]) begin
                        state <= GDE_DRAW;
                        draw_curve <= 1'b1;
                        draw_count <= `GDE_DRAW_CYCLES;
                        draw_cmd <= '0;
                        draw_cmd.curve <= 1'b1;
                        draw_cmd.shape <= {2'h0, reg_wdata[5:4]};
                        draw_cmd.fill <= reg_wdata[`GDE_BIT_CURVE_FILL];
                        draw_cmd.quarter <= reg_wdata[1:0];
                        {draw_cmd.cx, draw_cmd.cy} <= {center_x, center_y};
                        {draw_cmd.ra, draw_cmd.rb} <= {rad_major, rad_minor};
                        {draw_cmd.p1x, draw_cmd.p1y, draw_cmd.p2x} <= {pt[0], pt[1], pt[2]};
                        draw_cmd.p2y <= pt[3];
                    end
                end
                GDE_DRAW: begin
                    if ((!draw_curve && hit(`GDE_OFS_POLY_CTRL) && !reg_wdata[`GDE_BIT_START]) ||
                        (draw_curve && hit(`GDE_OFS_CURVE_CTRL) && !reg_wdata[`GDE_BIT_START]) ||
                        (draw_count == 16'h0001)) begin
                        state <= GDE_IDLE;
                        draw_count <= 16'h0000;
                    end else begin
                        draw_count <= draw_count - 16'h0001;
                    end
                end
            endcase
        end
    end

    // Busy level towards the pixel engine, one cycle behind the sequencer state.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            draw_busy <= 1'b0;
        end else begin
            draw_busy <= (state == GDE_DRAW);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read-back.

    logic busy_poly;
    logic busy_curve;
    logic [15:0] gsel_h;
    logic [15:0] gsel_v;
    logic [7:0] next_rdata;
    always_comb begin
        busy_poly = (state == GDE_DRAW) && !draw_curve;
        busy_curve = (state == GDE_DRAW) && draw_curve;
        // Choose prefetch or write cursor for the graphic position bytes.
        gsel_h = canvas_cfg[`GDE_BIT_READ_SEL] ? rpos_h : wpos_h;
        gsel_v = canvas_cfg[`GDE_BIT_READ_SEL] ? rpos_v : wpos_v;
        if (!canvas_cfg[`GDE_BIT_LINEAR]) begin
            gsel_h[15:13] = 3'h0;
            gsel_v[15:13] = 3'h0;
        end
        next_rdata = 8'h00;
        unique case (reg_addr)
            `GDE_OFS_AW_HEIGHT: next_rdata = aw_height[7:0];
            `GDE_OFS_AW_HEIGHT + 8'h01: next_rdata = {2'h0, aw_height[13:8]};
            `GDE_OFS_CANVAS: next_rdata = {4'h0, canvas_cfg};
            `GDE_OFS_GPOS_H: next_rdata = gsel_h[7:0];
            `GDE_OFS_GPOS_H + 8'h01: next_rdata = gsel_h[15:8];
            `GDE_OFS_GPOS_V: next_rdata = gsel_v[7:0];
            `GDE_OFS_GPOS_V + 8'h01: next_rdata = gsel_v[15:8];
            `GDE_OFS_TPOS_H: next_rdata = tpos_x[7:0];
            `GDE_OFS_TPOS_H + 8'h01: next_rdata = {3'h0, tpos_x[12:8]};
            `GDE_OFS_TPOS_V: next_rdata = tpos_y[7:0];
            `GDE_OFS_TPOS_V + 8'h01: next_rdata = {3'h0, tpos_y[12:8]};
            `GDE_OFS_POLY_CTRL: next_rdata = {busy_poly, 1'b0, poly_fill, poly_shape, 1'b0};
            `GDE_OFS_CURVE_CTRL: next_rdata = {busy_curve, curve_fill, curve_shape, 2'h0, quarter};
            `GDE_OFS_RAD_MAJOR: next_rdata = rad_major[7:0];
            `GDE_OFS_RAD_MAJOR + 8'h01: next_rdata = {3'h0, rad_major[12:8]};
            `GDE_OFS_RAD_MINOR: next_rdata = rad_minor[7:0];
            `GDE_OFS_RAD_MINOR + 8'h01: next_rdata = {3'h0, rad_minor[12:8]};
            `GDE_OFS_CENTER_H: next_rdata = center_x[7:0];
            `GDE_OFS_CENTER_H + 8'h01: next_rdata = {3'h0, center_x[12:8]};
            `GDE_OFS_CENTER_V: next_rdata = center_y[7:0];
            `GDE_OFS_CENTER_V + 8'h01: next_rdata = {3'h0, center_y[12:8]};
            `GDE_OFS_FG_RED: next_rdata = fg_red;
            default: begin
                // Endpoint bytes and unmapped offsets.
                for (int i = 0; i < 6; i++) begin
                    if (reg_addr == `GDE_OFS_P1_H + 8'(2 * i)) begin
                        next_rdata = pt[i][7:0];
                    end
                    if (reg_addr == `GDE_OFS_P1_H + 8'(2 * i + 1)) begin
                        next_rdata = {3'h0, pt[i][12:8]};
                    end
                end
            end
        endcase
    end

    // Read data is registered and marked by a one-cycle valid.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

endmodule : gde_regs

// File: dv/gde_regs_asserts.sv
// Checker of the drawing register block seen at its ports.
`timescale 1ns/1ps
module gde_chk (
    // Clock, reset and register port.
    input wire logic clk_sys, reset, reg_wr, reg_rd, reg_rvalid,
    input wire logic [7:0] reg_addr, reg_wdata,
    // Outputs under watch.
    input wire logic canvas_linear, mem_access_16, draw_busy,
    input wire logic [1:0] canvas_depth,
    input wire logic [13:0] window_height_eff,
    input wire logic [7:0] foreground_red_eff
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // A polygon start that reaches an idle engine must raise the busy level.
    sequence start_s;
        reg_wr && reg_addr == 8'h67 && reg_wdata[7] && !draw_busy;
    endsequence
    read_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("no answer");
    red_reset_a: assert property ($fell(reset) |-> foreground_red_eff == 8'hff)
        else $error("red reset");
    height_off_a: assert property (canvas_linear |-> window_height_eff == 14'h0)
        else $error("height");
    depth_off_a: assert property (canvas_linear |-> canvas_depth == 2'h0)
        else $error("depth");
    block_width_a: assert property (!canvas_linear |-> !mem_access_16)
        else $error("width");
    // The first edge after reset still shows the unmasked reset value.
    red_mask_a: assert property (canvas_depth == 2'h0 && !$past(reset) |->
        foreground_red_eff[4:0] == 5'h0) else $error("red mask");
    mode_follow_a: assert property (reg_wr && reg_addr == 8'h5e |->
        ##2 canvas_linear == $past(reg_wdata[2], 2)) else $error("mode");
    start_busy_a: assert property (start_s |-> ##[1:3] draw_busy)
        else $error("no start");
    busy_end_a: assert property ($rose(draw_busy) |-> ##[1:70] !draw_busy)
        else $error("no end");
endmodule : gde_chk
bind gde_regs gde_chk i_chk (.clk_sys(clk_sys), .reset(reset), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rvalid(reg_rvalid), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .canvas_linear(canvas_linear), .mem_access_16(mem_access_16), .draw_busy(draw_busy),
    .canvas_depth(canvas_depth), .window_height_eff(window_height_eff),
    .foreground_red_eff(foreground_red_eff));

// File: dv/tb.sv
// Self-checking testbench of the drawing register block.
`timescale 1ns/1ps
`include "gde_cfg.svh"
module tb;
    import gde_pkg::*;
    logic clk_sys = 0, reset = 1, reg_wr = 0, reg_rd = 0, rvalid, lin, acc16, busy;
    logic [7:0] addr = 0, wdata = 0, rdata, red, d;
    logic [1:0] depth;
    logic [13:0] height;
    logic [15:0] wx, wy, rx, ry;
    logic [12:0] tx, ty;
    gde_draw_t cmd;
    int n_errors = 0, checks = 0, seed = 58, cyc = 0, k, n;
    logic [7:0] m [0:255]; // Model of the stored bytes.
    gde_regs i_gde_regs (.clk_sys(clk_sys), .reset(reset), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .mem_wr_done(1'b0), .mem_rd_done(1'b0), .canvas_linear(lin),
        .canvas_depth(depth), .mem_access_16(acc16), .window_height_eff(height),
        .write_pos_x(wx), .write_pos_y(wy), .read_pos_x(rx), .read_pos_y(ry), .text_pos_x(tx),
        .text_pos_y(ty), .draw_cmd(cmd), .draw_busy(busy), .foreground_red_eff(red));
    initial forever #25 clk_sys = ~clk_sys;
    // Cycle ceiling, so a hung handshake still ends the run.
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            conclude();
        end
    end
    // Bits that read back; graphic high bytes show all bits only in linear mode.
    function automatic logic [7:0] msk(input logic [7:0] x);
        if (x == 8'h60 || x == 8'h62) return m[8'h5e][2] ? 8'hff : 8'h1f;
        if (x == 8'h5d) return 8'h3f;
        if (x == 8'h5e) return 8'h0f;
        if (x == 8'h67) return 8'h3e;
        if (x == 8'h76) return 8'h73;
        if (x inside {8'h5c, 8'h5f, 8'h61, 8'hd2}) return 8'hff;
        if (x inside {[8'h63:8'h66], [8'h77:8'h7e]}) return x[0] ? 8'hff : 8'h1f;
        if (x inside {[8'h68:8'h73]}) return x[0] ? 8'h1f : 8'hff;
        return 8'h00;
    endfunction : msk
    task chk(input logic [31:0] seen, exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    // Optional byte write, then a read of the same place; bx adds the busy bit.
    task acc(input logic wren, input logic [7:0] wa, wd, bx);
        if (wren) begin
            @(posedge clk_sys);
            addr <= wa;
            wdata <= wd;
            reg_wr <= 1;
            @(posedge clk_sys);
            reg_wr <= 0;
            m[wa] = (wa == 8'h60 || wa == 8'h62) ? wd : wd & msk(wa);
        end
        @(posedge clk_sys);
        addr <= wa;
        reg_rd <= 1;
        @(posedge clk_sys);
        reg_rd <= 0;
        #1;
        chk(rvalid, 1, "answer");
        chk(rdata, m[wa] & msk(wa) | bx, "byte");
    endtask : acc
    // Canvas outputs against the model of the configuration byte.
    task outs();
        logic [7:0] c;
        logic [1:0] e;
        logic [31:0] g;
        c = m[8'h5e];
        g = {m[8'h60] & msk(8'h60), m[8'h5f], m[8'h62] & msk(8'h62), m[8'h61]};
        e = c[2] ? 2'h0 : c[1] ? 2'h2 : {1'b0, c[0]};
        chk(lin, c[2], "linear");
        chk(depth, e, "depth");
        chk(acc16, c[2] & c[0], "width");
        chk(height, c[2] ? 14'h0 : {m[8'h5d][5:0], m[8'h5c]}, "height");
        chk(red, m[8'hd2] & (e[1] ? 8'hff : e[0] ? 8'hf8 : 8'he0), "red");
        chk({wx, wy}, g, "write pos");
        chk({rx, ry}, g, "read pos");
        chk({tx, ty}, {m[8'h64][4:0], m[8'h63], m[8'h66][4:0], m[8'h65]}, "text");
    endtask : outs
    task conclude();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    // Reset values, random traffic, three triangle folds, then a stopped curve.
    initial begin
        for (n = 0; n < 256; n++) m[n] = 8'h00;
        m[8'hd2] = 8'hff;
        repeat (8) @(posedge clk_sys);
        reset <= 0;
        for (n = 8'h5c; n < 8'h81; n++) acc(0, 8'(n), 0, 0);
        acc(0, 8'hd2, 0, 0);
        outs();
        // Window height is set before any cursor write.
        acc(1, 8'h5c, 8'h40, 0);
        acc(1, 8'h5d, 8'h01, 0);
        repeat (150) begin
            n = {$random(seed)} % 36;
            d = $random(seed);
            if (n == 11 || n == 26) d[7] = 0;
            acc(1, n == 35 ? 8'hd2 : 8'(8'h5c + n), d, 0);
            outs();
        end
        for (k = 0; k < 3; k++) begin
            for (n = 8'h68; n < 8'h74; n++) begin
                // A dot, then a line (points two and three meet), then three distinct corners.
                d = (k == 2) ? 8'(n) : (n < 8'h6c || k == 0) ? 8'h05 : 8'h09;
                acc(1, 8'(n), n[0] ? 8'h00 : d, 0);
            end
            acc(1, 8'h67, 8'ha2, 8'h80);
            chk(cmd.kind, 2 - k, "kind");
            chk({cmd.fill, cmd.shape}, 5'h11, "mode");
            n = 0;
            while (busy === 1'b1 && n < 100) begin
                @(posedge clk_sys) #1;
                n++;
            end
            chk(n, `GDE_DRAW_CYCLES - 1, "length");
            acc(0, 8'h67, 0, 0);
        end
        for (n = 8'h77; n < 8'h7b; n++) acc(1, 8'(n), n[0] ? 8'h10 : 8'h01, 0);
        acc(1, 8'h76, 8'hc3, 8'h80);
        chk({cmd.curve, cmd.fill, cmd.shape[1:0], cmd.quarter}, 6'h33, "curve");
        chk({cmd.ra, cmd.rb}, {13'h0110, 13'h0110}, "radii");
        acc(1, 8'h76, 8'h43, 0);
        chk(busy, 0, "stop");
        conclude();
    end
endmodule : tb
